//--- sdh_sdma_top.sv
// sdh_sdma_top: simple-dma address / argument-2 register and the sdma
// mover that walks it, plus auto cmd23 argument and interrupt logic.
// assumes the card data stream and memory port share i_clk.
// assumes software keeps each transfer length a multiple of four bytes.
//
// How it works
// - crossing the buffer boundary sets the dma flag and pauses transfer
// - on completion the register holds the next contiguous address
// - resume or continue bit restarts from the address in the register
// - address reads are trustworthy only while paused at a boundary or once the walk completes
// - advanced dma ignores the simple-dma address contents
// - with auto cmd23 enabled the register is the cmd23 argument
// - adma allows a full 32-bit count, otherwise capped at 65535
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module sdh_sdma_top
  import sdh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  input wire logic i_card_valid,
  input wire logic [31:0] i_card_data,
  output logic o_card_ready,
  output sdh_mem_s o_mem,
  input wire logic i_mem_ready,
  output logic o_cmd23_valid,
  output logic [31:0] o_cmd23_arg,
  output logic o_adma_start,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // register map, byte offsets on the ahb side
  // ----------------------------------------------------------------
  // 0x00 dma_address_argument: rw, frozen while the mover runs
  // 0x04 transfer_block_size: [11:0] block bytes, [14:12] buffer size
  // 0x08 block count: [15:0]
  // 0x0c control: start, adma, auto cmd23 enable, resume
  // 0x10 block_gap_control: continue, write one, reads zero
  // 0x14 interrupt status: complete, dma boundary; read only
  // 0x18 interrupt clear: write one clears, reads zero
  // 0x1c interrupt enable: same layout as the status
  // 0x20 mover state: running, paused; read only
  // unmapped offsets read zero and ignore writes
  // buffer size is 4 kb shifted left by the [14:12] field
  // mode bits change only while idle, so a walk never switches mode

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // everything the block remembers, registered in one place
  typedef struct packed {
    logic [31:0] addr;
    logic [2:0] hb;
    logic [11:0] bsize;
    logic [15:0] bcnt;
    logic adma;
    logic auto23;
    logic [1:0] stat;
    logic [1:0] ien;
    sdh_dma_e dma;
    logic [27:0] remain;
    sdh_mem_s mem;
    logic cmd23_v;
    logic [31:0] cmd23_arg;
    logic adma_go;
  } sdh_core_s;

  // reset image: idle mover, no beat, masked interrupts
  localparam sdh_core_s SDH_CORE_RST = '{
    addr: SDH_ADDR_RST,
    hb: SDH_HB_RST,
    bsize: SDH_BSIZE_RST,
    bcnt: SDH_BCNT_RST,
    adma: 1'b0,
    auto23: 1'b0,
    stat: SDH_IRQ_RST,
    ien: SDH_IRQ_RST,
    dma: SDH_IDLE,
    remain: 28'h000_0000,
    mem: '{1'b0, 32'h0000_0000, 32'h0000_0000},
    cmd23_v: 1'b0,
    cmd23_arg: 32'h0000_0000,
    adma_go: 1'b0
  };

  // registered state, its next value and the bus taps
  sdh_core_s s_q;
  sdh_core_s s_d;
  sdh_regacc_s acc;
  logic [7:0] raddr;
  logic [31:0] rdata;

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  // one wait state on reads keeps read data straight from a flop
  sdh_ahb_if u_ahb (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_hsel(i_hsel),
    .i_haddr(i_haddr),
    .i_htrans(i_htrans),
    .i_hwrite(i_hwrite),
    .i_hsize(i_hsize),
    .i_hwdata(i_hwdata),
    .i_hready(i_hready),
    .i_rdata(rdata),
    .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp),
    .o_hrdata(o_hrdata),
    .o_raddr(raddr),
    .o_acc(acc)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when the address sits on a host buffer boundary (4 kb << hb)
  function automatic logic sdh_on_bnd(input logic [31:0] a, input logic [2:0] hb);
    logic [31:0] mask;
    // the widest buffer still leaves the mask well inside 32 bits
    mask = (SDH_BND_BASE << hb) - 32'h0000_0001;
    return ((a & mask) == 32'h0000_0000);
  endfunction : sdh_on_bnd

  // without adma the card count cannot exceed sixteen bits
  function automatic logic [31:0] sdh_arg23(input logic [31:0] v, input logic adma);
    logic [31:0] r;
    // the cap only bites on starts without adma
    r = v;
    if (!adma && (v > SDH_ARG_CAP)) begin
      r = SDH_ARG_CAP;
    end
    return r;
  endfunction : sdh_arg23

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // mover walk, one word at a time:
  //   run: take a card word, then hold it as a memory beat
  //   beat: on memory ready step the address by four bytes
  //   last: four bytes or fewer left ends the walk and flags complete
  //   edge: a new address on a buffer edge pauses and flags dma
  //   pause: continue or resume restarts only once the flag is clear
  // completion beats the edge test, so a walk ending on a buffer
  // edge never leaves a stale pause behind
  // limitation: only card to memory is built and beats are whole words;
  // a length that is not a multiple of four still moves a full last word
  // reads of the address while running show the live walk, which
  // software should trust only at a boundary pause or once the walk completes
  // at least two cycles pass per word; the card is held off meanwhile
  always_comb begin
    logic start;
    logic resume;
    logic new_adma;
    logic new_auto;
    logic set_cmp;
    logic set_dma;
    logic [31:0] next_addr;
    logic [27:0] total;

    // candidate values; each is used only where a branch needs it
    start = 1'b0;
    resume = 1'b0;
    new_adma = s_q.adma;
    new_auto = s_q.auto23;
    set_cmp = 1'b0;
    set_dma = 1'b0;
    next_addr = s_q.addr + SDH_STEP;
    total = 28'(s_q.bsize * s_q.bcnt);
    s_d = s_q;
    // pulses last one cycle unless a start sets them again
    s_d.cmd23_v = 1'b0;
    s_d.adma_go = 1'b0;

    // register writes; the address is frozen while the mover owns it
    if (acc.wr) begin
      if (acc.addr == SDH_OFS_ADDR) begin
        if (s_q.dma != SDH_RUN) begin
          s_d.addr = acc.wdata;
        end
      end else if (acc.addr == SDH_OFS_BLKSZ) begin
        // size takes effect at the next start; the buffer field is used at once, even mid-walk
        s_d.bsize = acc.wdata[SDH_BS_SIZE_LSB +: 12];
        s_d.hb = acc.wdata[SDH_BS_HB_LSB +: 3];
      end else if (acc.addr == SDH_OFS_BCNT) begin
        s_d.bcnt = acc.wdata[SDH_BC_LSB +: 16];
      end else if (acc.addr == SDH_OFS_CTRL) begin
        // start and resume are write-one pulses and are never stored
        new_adma = acc.wdata[SDH_CTL_ADMA];
        new_auto = acc.wdata[SDH_CTL_AUTO23];
        start = acc.wdata[SDH_CTL_START];
        resume = acc.wdata[SDH_CTL_RESUME];
        if (s_q.dma == SDH_IDLE) begin
          s_d.adma = new_adma;
          s_d.auto23 = new_auto;
        end
      end else if (acc.addr == SDH_OFS_GAP) begin
        // continue reads back as zero; it only nudges a paused walk
        resume = acc.wdata[SDH_GAP_CONT];
      end else if (acc.addr == SDH_OFS_ICLR) begin
        // a flag raised in this same cycle still wins further down
        s_d.stat = s_q.stat & ~acc.wdata[1:0];
      end else if (acc.addr == SDH_OFS_IEN) begin
        s_d.ien = acc.wdata[1:0];
      end
    end

    // start: auto cmd23 argument and adma pulse in the same cycle, or simple dma when both are off
    if (start && (s_q.dma == SDH_IDLE)) begin
      if (new_auto) begin
        s_d.cmd23_v = 1'b1;
        s_d.cmd23_arg = sdh_arg23(s_q.addr, new_adma);
      end
      if (new_adma) begin
        s_d.adma_go = 1'b1;
      end else if (new_auto) begin
        // register holds the count, so there is no address to walk
        s_d.adma_go = 1'b0;
      end else if (total == 28'h000_0000) begin
        // a zero length finishes at once with nothing moved
        set_cmp = 1'b1;
      end else begin
        s_d.dma = SDH_RUN;
        s_d.remain = total;
      end
    end

    // mover state machine
    case (s_q.dma)
      SDH_RUN: begin
        // a pending beat waits for memory, else fetch the next word
        if (s_q.mem.valid) begin
          if (i_mem_ready) begin
            s_d.mem.valid = 1'b0;
            s_d.addr = next_addr;
            // the last beat ends the walk even on a buffer edge
            if (s_q.remain <= SDH_STEP_LEN) begin
              s_d.remain = 28'h000_0000;
              s_d.dma = SDH_IDLE;
              set_cmp = 1'b1;
            end else begin
              s_d.remain = s_q.remain - SDH_STEP_LEN;
              if (sdh_on_bnd(next_addr, s_q.hb)) begin
                s_d.dma = SDH_PAUSE;
                set_dma = 1'b1;
              end
            end
          end
        end else if (i_card_valid) begin
          // word and address travel together as one beat
          s_d.mem.valid = 1'b1;
          s_d.mem.addr = s_q.addr;
          s_d.mem.data = i_card_data;
        end
      end
      SDH_PAUSE: begin
        // a stale dma flag keeps the pause; the driver must clear it first
        if (resume && !s_q.stat[SDH_IRQ_DMA]) begin
          s_d.dma = SDH_RUN;
        end
      end
      default: begin
        // idle: the start decode above has already picked the next state
      end
    endcase

    // sticky status: a new event beats a clear in the same cycle
    if (set_cmp) begin
      s_d.stat[SDH_IRQ_CMP] = 1'b1;
    end
    if (set_dma) begin
      s_d.stat[SDH_IRQ_DMA] = 1'b1;
    end
  end

  // one register stage for all state; reset loads constants only
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= SDH_CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  // the address reads back raw mid-transfer; a boundary pause or completion makes it exact
  always_comb begin
    rdata = 32'h0000_0000;
    if (raddr == SDH_OFS_ADDR) begin
      rdata = s_q.addr;
    end else if (raddr == SDH_OFS_BLKSZ) begin
      rdata[SDH_BS_SIZE_LSB +: 12] = s_q.bsize;
      rdata[SDH_BS_HB_LSB +: 3] = s_q.hb;
    end else if (raddr == SDH_OFS_BCNT) begin
      rdata[SDH_BC_LSB +: 16] = s_q.bcnt;
    end else if (raddr == SDH_OFS_CTRL) begin
      // start and resume are pulses and read back as zero
      rdata[SDH_CTL_ADMA] = s_q.adma;
      rdata[SDH_CTL_AUTO23] = s_q.auto23;
    end else if (raddr == SDH_OFS_ISTAT) begin
      rdata[1:0] = s_q.stat;
    end else if (raddr == SDH_OFS_IEN) begin
      rdata[1:0] = s_q.ien;
    end else if (raddr == SDH_OFS_STATE) begin
      // running and paused are one-hot; idle reads zero
      rdata[SDH_ST_BUSY] = (s_q.dma == SDH_RUN);
      rdata[SDH_ST_PAUSE] = (s_q.dma == SDH_PAUSE);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // card is stalled while a memory beat is pending or the mover is paused
  assign o_card_ready = (s_q.dma == SDH_RUN) && !s_q.mem.valid;
  assign o_mem = s_q.mem;
  // pulses and the argument come straight from flip-flops
  assign o_cmd23_valid = s_q.cmd23_v;
  assign o_cmd23_arg = s_q.cmd23_arg;
  assign o_adma_start = s_q.adma_go;
  // level interrupt while any enabled sticky flag is set
  assign o_irq = |(s_q.stat & s_q.ien);

endmodule : sdh_sdma_top
`default_nettype wire

//--- sdh_pkg.sv
// sdh_pkg: register map, field layout, reset values and shared types
// for the simple-dma address / argument-2 block.
// assumes a 32-bit ahb-lite register bus and a 32-bit system memory port.
package sdh_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SDH_OFS_ADDR = 8'h00;
  localparam logic [7:0] SDH_OFS_BLKSZ = 8'h04;
  localparam logic [7:0] SDH_OFS_BCNT = 8'h08;
  localparam logic [7:0] SDH_OFS_CTRL = 8'h0c;
  localparam logic [7:0] SDH_OFS_GAP = 8'h10;
  localparam logic [7:0] SDH_OFS_ISTAT = 8'h14;
  localparam logic [7:0] SDH_OFS_ICLR = 8'h18;
  localparam logic [7:0] SDH_OFS_IEN = 8'h1c;
  localparam logic [7:0] SDH_OFS_STATE = 8'h20;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SDH_BS_SIZE_LSB = 0;
  localparam int SDH_BS_HB_LSB = 12;
  localparam int SDH_BC_LSB = 0;
  localparam int SDH_CTL_START = 0;
  localparam int SDH_CTL_ADMA = 1;
  localparam int SDH_CTL_AUTO23 = 2;
  localparam int SDH_CTL_RESUME = 3;
  localparam int SDH_GAP_CONT = 0;
  localparam int SDH_IRQ_CMP = 0;
  localparam int SDH_IRQ_DMA = 1;
  localparam int SDH_ST_BUSY = 0;
  localparam int SDH_ST_PAUSE = 1;

  // ----------------------------------------------------------------
  // reset values and arithmetic constants
  // ----------------------------------------------------------------
  localparam logic [31:0] SDH_ADDR_RST = 32'h0000_0000;
  localparam logic [2:0] SDH_HB_RST = 3'h0;
  localparam logic [11:0] SDH_BSIZE_RST = 12'h000;
  localparam logic [15:0] SDH_BCNT_RST = 16'h0000;
  localparam logic [1:0] SDH_IRQ_RST = 2'h0;
  localparam logic [31:0] SDH_STEP = 32'h0000_0004;
  localparam logic [27:0] SDH_STEP_LEN = 28'h000_0004;
  localparam logic [31:0] SDH_BND_BASE = 32'h0000_1000;
  localparam logic [31:0] SDH_ARG_CAP = 32'h0000_ffff;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDH_IDLE = 2'b00,
    SDH_RUN = 2'b01,
    SDH_PAUSE = 2'b10
  } sdh_dma_e;

  typedef enum logic [1:0] {
    SDH_RD_NONE = 2'b00,
    SDH_RD_WAIT = 2'b01,
    SDH_RD_DONE = 2'b10
  } sdh_rd_e;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sdh_regacc_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } sdh_mem_s;

endpackage : sdh_pkg

//--- sdh_ahb_if.sv
// sdh_ahb_if: ahb-lite slave front end for the sdma register file.
// assumes single word transfers; reads take one wait state so that
// hrdata comes straight from a flip-flop.
`timescale 1ns/10ps
`default_nettype none
module sdh_ahb_if
  import sdh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] i_rdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  output logic [7:0] o_raddr,
  output sdh_regacc_s o_acc
);

  typedef struct packed {
    logic wph;
    sdh_rd_e rph;
    logic [7:0] addr;
    logic [31:0] rdata;
  } sdh_ahb_s;

  sdh_ahb_s s_q;
  sdh_ahb_s s_d;

  // address phase capture; hsize is only checked against 7, only words are expected
  always_comb begin
    s_d = s_q;
    s_d.wph = 1'b0;
    case (s_q.rph)
      SDH_RD_WAIT: begin
        s_d.rph = SDH_RD_DONE;
        s_d.rdata = i_rdata;
      end
      SDH_RD_DONE: s_d.rph = SDH_RD_NONE;
      default: s_d.rph = SDH_RD_NONE;
    endcase
    if (o_hreadyout && i_hready && i_hsel && i_htrans[1] && (i_hsize != 3'h7)) begin
      s_d.addr = i_haddr[7:0];
      s_d.wph = i_hwrite;
      if (!i_hwrite) begin
        s_d.rph = SDH_RD_WAIT;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '{1'b0, SDH_RD_NONE, 8'h00, 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // writes land during the zero-wait data phase, hwdata is valid then
  assign o_acc.wr = s_q.wph;
  assign o_acc.addr = s_q.addr;
  assign o_acc.wdata = i_hwdata;
  assign o_raddr = s_q.addr;
  assign o_hreadyout = (s_q.rph != SDH_RD_WAIT);
  assign o_hresp = 1'b0;
  assign o_hrdata = s_q.rdata;

endmodule : sdh_ahb_if
`default_nettype wire

//--- sdh_sdma_assertions.sv
// sdh_sdma_assertions: port-level checks for the sdma address block.
// assumes it is bound into sdh_sdma_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module sdh_sdma_chk
  import sdh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_card_valid,
  input wire logic [31:0] i_card_data,
  input wire logic o_card_ready,
  input wire sdh_mem_s o_mem,
  input wire logic i_mem_ready,
  input wire logic o_cmd23_valid,
  input wire logic [31:0] o_cmd23_arg,
  input wire logic o_adma_start,
  input wire logic o_irq
);
  // ------------------------------------------------------------
  // bus, mover and pulse properties
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic take;
  // an address phase is accepted only while the slave is ready
  assign take = i_hsel & i_hready & i_htrans[1] & o_hreadyout;
  a_read_wait: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && i_hwrite |=> o_hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (o_hresp == 1'b0)
    else $error("response not okay");
  a_word_to_mem: assert property (
    i_card_valid && o_card_ready |=> o_mem.valid && o_mem.data == $past(i_card_data))
    else $error("card word lost");
  a_beat_hold: assert property (o_mem.valid && !i_mem_ready |=> $stable(o_mem))
    else $error("beat changed while stalled");
  a_card_gate: assert property (o_card_ready |-> !o_mem.valid)
    else $error("card taken with beat pending");
  // only back-to-back beats are checked; a pause needs a software write
  a_step_four: assert property (
    o_mem.valid && i_mem_ready ##1 o_card_ready && i_card_valid
    |=> o_mem.addr == $past(o_mem.addr, 2) + 32'h4)
    else $error("address step not four");
  a_cmd23_pulse: assert property (o_cmd23_valid |=> !o_cmd23_valid)
    else $error("cmd23 pulse too long");
  a_arg_hold: assert property ($changed(o_cmd23_arg) |-> o_cmd23_valid)
    else $error("argument moved without pulse");
  a_adma_pulse: assert property (o_adma_start |=> !o_adma_start)
    else $error("adma pulse too long");
  c_beat: cover property (o_mem.valid && i_mem_ready);
  c_cmd23: cover property (o_cmd23_valid);
  c_adma: cover property (o_adma_start);
  c_irq: cover property (o_irq);
endmodule : sdh_sdma_chk
bind sdh_sdma_top sdh_sdma_chk u_chk (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_hsel(i_hsel),
  .i_htrans(i_htrans),
  .i_hwrite(i_hwrite),
  .i_hready(i_hready),
  .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp),
  .i_card_valid(i_card_valid),
  .i_card_data(i_card_data),
  .o_card_ready(o_card_ready),
  .o_mem(o_mem),
  .i_mem_ready(i_mem_ready),
  .o_cmd23_valid(o_cmd23_valid),
  .o_cmd23_arg(o_cmd23_arg),
  .o_adma_start(o_adma_start),
  .o_irq(o_irq)
);
`default_nettype wire

//--- sdh_card_model.sv
// sdh_card_model: card-side word stream feeding the sdma mover.
// assumes the stream shares the controller clock; words count upward.
`timescale 1ns/10ps
`default_nettype none
module sdh_card_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_ready,
  input wire logic i_slow,
  output logic o_valid,
  output logic [31:0] o_data
);
  // ------------------------------------------------------------
  // word source
  // ------------------------------------------------------------
  logic [31:0] word_q;
  logic [1:0] gap_q;
  // junk between words so a stale word can never pass as a good one
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_valid <= 1'b0;
      o_data <= 32'hffff_ffff;
      word_q <= 32'hc0de_0000;
      gap_q <= 2'h0;
    end else if (o_valid && i_ready) begin
      word_q <= word_q + 32'h1;
      o_valid <= !i_slow;
      o_data <= i_slow ? ~word_q : word_q + 32'h1;
      gap_q <= 2'h3;
    end else if (!o_valid && (gap_q == 2'h0 || !i_slow)) begin
      o_valid <= 1'b1;
      o_data <= word_q;
    end else if (!o_valid) begin
      gap_q <= gap_q - 2'h1;
      o_data <= ~o_data;
    end
  end
endmodule : sdh_card_model
`default_nettype wire

//--- tb_sd_host_sdma_address_arg2.sv
// tb_sd_host_sdma_address_arg2: self-checking bench for sdh_sdma_top.
// assumes one 50 mhz clock; the bench is the only ahb-lite master.
`timescale 1ns/10ps
`default_nettype none
module tb_sd_host_sdma_address_arg2;
  import sdh_pkg::*;
  logic i_clk, i_reset, hsel, hwrite, mem_rdy, slow, hready, hresp;
  logic cvalid, cready, c23, adma, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, cdata, arg, arg23, q, a, v;
  logic [31:0] exp_addr;
  sdh_mem_s mem;
  int errors, n_tests, cyc, n23, nad, nbeat, s23, sad, sbt, bb;
  sdh_sdma_top dut (.i_clk(i_clk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_card_valid(cvalid), .i_card_data(cdata), .o_card_ready(cready), .o_mem(mem),
    .i_mem_ready(mem_rdy), .o_cmd23_valid(c23), .o_cmd23_arg(arg),
    .o_adma_start(adma), .o_irq(irq));
  sdh_card_model card (.i_clk(i_clk), .i_reset(i_reset), .i_ready(cready),
    .i_slow(slow), .o_valid(cvalid), .o_data(cdata));
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ------------------------------------------------------------
  // checking, expectations and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  function automatic logic [31:0] f_bnd(input logic [31:0] ad);
    return (ad | (SDH_BND_BASE - 32'h1)) + 32'h1;
  endfunction : f_bnd
  function automatic logic [31:0] f_arg(input logic [31:0] x, input logic ad);
    return (ad || x < SDH_ARG_CAP) ? x : SDH_ARG_CAP;
  endfunction : f_arg
  // each phase is held until hready is sampled high at a rising edge
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    hwrite <= w;
    haddr <= {24'h0, ad};
    htrans <= 2'b10;
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0);
  endtask : rd
  task automatic wait_flag(input int b);
    do rd(SDH_OFS_ISTAT); while (q[b] !== 1'b1);
  endtask : wait_flag
  task automatic chk_irq(input logic e);
    @(negedge i_clk);
    chk({31'h0, irq}, {31'h0, e});
    @(posedge i_clk);
  endtask : chk_irq
  // beats must walk up from the programmed address, card words in order
  always @(posedge i_clk) begin
    mem_rdy <= ($urandom % 4) != 0;
    if (!i_reset && mem.valid === 1'b1 && mem_rdy === 1'b1) begin
      chk(mem.addr, exp_addr + 32'(4 * (nbeat - bb)));
      chk(mem.data, 32'hc0de_0000 + 32'(nbeat));
      nbeat++;
    end
    if (c23 === 1'b1) begin
      n23++;
      arg23 = arg;
    end
    if (adma === 1'b1) nad++;
  end
  // a hang is cut short well beyond the expected run length
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      test_done;
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    i_reset = 1'b1;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    slow = 1'b0;
    void'($urandom(48));
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(SDH_OFS_ADDR);
    chk(q, SDH_ADDR_RST);
    v = $urandom;
    wr(SDH_OFS_ADDR, v);
    rd(SDH_OFS_ADDR);
    chk(q, v);
    rd(8'h40);
    chk(q, 32'h0);
    $display("test registers done");
    // two blocks inside one buffer, then the masked and enabled interrupt
    a = {v[31:12], 12'h100};
    slow <= v[0];
    wr(SDH_OFS_ADDR, a);
    exp_addr = a;
    bb = nbeat;
    wr(SDH_OFS_BLKSZ, 32'h10);
    wr(SDH_OFS_BCNT, 32'h2);
    wr(SDH_OFS_CTRL, 32'h1);
    wait_flag(SDH_IRQ_CMP);
    rd(SDH_OFS_ADDR);
    chk(q, a + 32'h20);
    chk_irq(1'b0);
    wr(SDH_OFS_IEN, 32'h3);
    chk_irq(1'b1);
    wr(SDH_OFS_ICLR, 32'h1);
    chk_irq(1'b0);
    $display("test plain transfer done");
    // two pauses; continue before the flag is cleared must be refused
    a = {v[31:12] ^ 20'h1, 12'hff8};
    slow <= ~v[0];
    wr(SDH_OFS_ADDR, a);
    exp_addr = a;
    bb = nbeat;
    wr(SDH_OFS_BCNT, 32'h1);
    wr(SDH_OFS_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      wait_flag(SDH_IRQ_DMA);
      chk_irq(1'b1);
      rd(SDH_OFS_ADDR);
      chk(q, f_bnd(a));
      wr(SDH_OFS_GAP, 32'h1);
      rd(SDH_OFS_STATE);
      chk(q, 32'h2);
      v = $urandom;
      a = {v[19:0], 12'hffc};
      wr(SDH_OFS_ADDR, a);
      exp_addr = a;
      bb = nbeat;
      wr(SDH_OFS_ICLR, 32'h2);
      if (i == 0) wr(SDH_OFS_GAP, 32'h1);
      else wr(SDH_OFS_CTRL, 32'h8);
    end
    wait_flag(SDH_IRQ_CMP);
    rd(SDH_OFS_ADDR);
    chk(q, a + 32'h4);
    wr(SDH_OFS_ICLR, 32'h3);
    $display("test boundary pauses done");
    // argument-only, argument with advanced dma, advanced dma alone
    for (int i = 0; i < 3; i++) begin
      v = $urandom | 32'h0001_0000;
      s23 = n23;
      sad = nad;
      sbt = nbeat;
      wr(SDH_OFS_ADDR, v);
      wr(SDH_OFS_CTRL, (i == 2) ? 32'h3 : 32'h5 + 32'(2 * i));
      repeat (4) @(posedge i_clk);
      chk(32'(n23 - s23), 32'(i < 2));
      if (i < 2) chk(arg23, f_arg(v, i == 1));
      chk(32'(nad - sad), 32'(i > 0));
      chk(32'(nbeat - sbt), 32'h0);
    end
    $display("test auto cmd23 done");
    test_done;
  end
endmodule : tb_sd_host_sdma_address_arg2
`default_nettype wire
